// ### logic/fbsel_regs_top.sv
// fieldbus selection register bank: availability, control and status words
// assumes one clock, a synchronous reset and a classic wishbone master;
// fitted and switchable sets are fixed at build time by parameters
//
// Function
// - a read-only 32-bit availability word has physical interfaces in bits 0-15 and protocols in bits 16-31.
// - availability bits are usb 0, rs485 1, rs232 2, can 3, ethernet 4, industrial fieldbus 5 and spi 6.
// - protocol bits are serial modbus 16, tcp modbus 17 and industrial protocol 18.
// - the availability word reads 0x00000008 in reset, only the can bit set, then AVAIL_FITTED masked to the defined bits from the first enabled cycle.
// - a read/write control word with the same layout lets the host switch interfaces, resets to 0x8 and can be saved.
// - the control word switches only those bits that the switchable mask flags.
// - the status count entry is 8 bits wide and reads 0x02, followed by two 32-bit bitmaps.
// - the switchable mask is read-only with the common layout and resets to zero.
// - the active map is read-only with the common layout and resets to 0x00000008.
// - a one in the active map means active, and a one in the switchable mask means it can be deactivated.
`timescale 1ns/1ps
`default_nettype none
`include "fbsel_regs.svh"

module fbsel_regs_top #(
  parameter int ADDR_W = 16,
  parameter logic [31:0] AVAIL_FITTED = `FBSEL_AVAIL_RST,
  parameter logic [31:0] SWITCHABLE = `FBSEL_SWMASK_RST,
  parameter int CHANGE_W = 16
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // saved communication settings
  input wire logic restore_stb_i,
  input wire logic [31:0] restore_data_i,
  output logic [31:0] save_data_o,
  output logic save_req_o,
  // towards the interface blocks
  output logic [31:0] active_map_o,
  output logic active_change_o
);

  // only bits with a meaning in the layout can ever be fitted or switched
  localparam logic [31:0] FITTED_EFF = AVAIL_FITTED & `FBSEL_DEFINED_MASK;
  localparam logic [31:0] SWITCH_EFF = SWITCHABLE & `FBSEL_DEFINED_MASK;

  fbsel_pkg::fbsel_reg_sel_t reg_sel;
  wire logic wr_stb;
  wire logic [31:0] wr_lanes;
  logic bus_ack;
  logic [31:0] bus_dat;

  // register state
  logic [31:0] avail_q;
  logic [31:0] swmask_q;
  logic [7:0] count_q;
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] active_q;
  logic [31:0] active_d;
  logic [CHANGE_W-1:0] changes_q;
  logic [CHANGE_W-1:0] changes_d;
  logic save_q;
  logic change_q;

  // decode and masking
  wire logic ctrl_wr;
  wire logic [31:0] ctrl_wr_mask;
  wire logic [31:0] restore_mask;
  wire logic [31:0] ctrl_after_restore;
  wire logic [31:0] ctrl_after_write;
  wire logic [31:0] active_target;
  wire logic any_change;
  wire logic ctrl_moved;
  wire logic [31:0] rd_data;
  wire logic [31:0] rd_avail;
  wire logic [31:0] rd_ctrl;
  wire logic [31:0] rd_count;
  wire logic [31:0] rd_swmask;
  wire logic [31:0] rd_active;
  wire logic [31:0] rd_changes;

  fbsel_wb_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_ack_o(bus_ack),
    .wb_dat_o(bus_dat),
    .rd_data_i(rd_data),
    .reg_sel_o(reg_sel),
    .wr_stb_o(wr_stb),
    .wr_lanes_o(wr_lanes)
  );

  assign wb_ack_o = bus_ack;
  assign wb_dat_o = bus_dat;

  // ---- control word path ----
  // writes to the read-only words fall through here and are dropped
  assign ctrl_wr = wr_stb & (reg_sel == fbsel_pkg::FBSEL_SEL_CTRL);
  // byte lanes and the switchable set together decide which bits move
  assign ctrl_wr_mask = ctrl_wr ? (wr_lanes & SWITCH_EFF) : 32'h00000000;
  // a restored image goes through the same gate: an old file cannot
  // switch something this build treats as fixed
  assign restore_mask = restore_stb_i ? SWITCH_EFF : 32'h00000000;
  assign ctrl_after_restore = (ctrl_q & ~restore_mask) | (restore_data_i & restore_mask);
  // a bus write in the same cycle as a restore wins, being the newer intent
  assign ctrl_after_write = (ctrl_after_restore & ~ctrl_wr_mask) | (wb_dat_i & ctrl_wr_mask);

  always_comb
  begin
    ctrl_d = ctrl_after_write;
  end

  assign ctrl_moved = (ctrl_d != ctrl_q);

  // ---- active map ----
  // a switchable bit is active when requested and the interface is fitted;
  // fixed bits keep their reset value for good
  assign active_target = ctrl_q & avail_q;

  genvar b;
  generate
    for (b = 0; b < 32; b++)
    begin : g_active
      if (SWITCH_EFF[b])
      begin : g_sw
        assign active_d[b] = active_target[b];
      end
      else
      begin : g_fixed
        assign active_d[b] = active_q[b];
      end
    end
  endgenerate

  assign any_change = (active_d != active_q);

  // count of active map changes, saturating so a wrap cannot hide activity
  always_comb
  begin
    changes_d = changes_q;
    if (any_change && (changes_q != {CHANGE_W{1'b1}}))
      changes_d = changes_q + CHANGE_W'(1);
  end

  // ---- state ----
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      avail_q <= `FBSEL_AVAIL_RST;
      swmask_q <= `FBSEL_SWMASK_RST;
      count_q <= `FBSEL_COUNT_RST;
      ctrl_q <= `FBSEL_CTRL_RST;
      active_q <= `FBSEL_ACTIVE_RST;
      changes_q <= CHANGE_W'(`FBSEL_CHANGES_RST);
      save_q <= 1'b0;
      change_q <= 1'b0;
    end
    else if (ce_i)
    begin
      // fitted and switchable sets take the build's values after reset
      avail_q <= FITTED_EFF;
      swmask_q <= SWITCH_EFF;
      count_q <= `FBSEL_COUNT_RST;
      ctrl_q <= ctrl_d;
      active_q <= active_d;
      changes_q <= changes_d;
      // ask the settings store to save only when a host write lands in a cycle that moves control bits, whether by the write or by a restore
      save_q <= ctrl_wr & ctrl_moved;
      change_q <= any_change;
    end
  end

  // ---- read mux ----
  assign rd_avail = avail_q;
  assign rd_ctrl = ctrl_q;
  assign rd_count = {24'h000000, count_q};
  assign rd_swmask = swmask_q;
  assign rd_active = active_q;
  assign rd_changes = {{(32 - CHANGE_W){1'b0}}, changes_q};

  // unmapped reads answer zero so a stray probe still completes
  assign rd_data = (reg_sel == fbsel_pkg::FBSEL_SEL_AVAIL) ? rd_avail :
                   (reg_sel == fbsel_pkg::FBSEL_SEL_CTRL) ? rd_ctrl :
                   (reg_sel == fbsel_pkg::FBSEL_SEL_COUNT) ? rd_count :
                   (reg_sel == fbsel_pkg::FBSEL_SEL_SWMASK) ? rd_swmask :
                   (reg_sel == fbsel_pkg::FBSEL_SEL_ACTIVE) ? rd_active :
                   (reg_sel == fbsel_pkg::FBSEL_SEL_CHANGES) ? rd_changes :
                   32'h00000000;

  // ---- outputs ----
  assign save_data_o = ctrl_q;
  assign save_req_o = save_q;
  assign active_map_o = active_q;
  assign active_change_o = change_q;

endmodule
`default_nettype wire

// ### shared/fbsel_regs.svh
// fieldbus selection register bank: offsets, bit positions and reset values
// assumes byte addressing on a 32-bit classic wishbone bus
`ifndef FBSEL_REGS_SVH
`define FBSEL_REGS_SVH

// register indices; byte address is four times the index
`define FBSEL_IDX_AVAIL 16'h2101
`define FBSEL_IDX_CTRL 16'h2102
`define FBSEL_IDX_COUNT 16'h2103
`define FBSEL_IDX_SWMASK 16'h2104
`define FBSEL_IDX_ACTIVE 16'h2105
`define FBSEL_IDX_CHANGES 16'h2106
`define FBSEL_ADDR_AVAIL 16'h8404
`define FBSEL_ADDR_CTRL 16'h8408
`define FBSEL_ADDR_COUNT 16'h840c
`define FBSEL_ADDR_SWMASK 16'h8410
`define FBSEL_ADDR_ACTIVE 16'h8414
`define FBSEL_ADDR_CHANGES 16'h8418

// common bitmap layout, physical interfaces in the low half
`define FBSEL_USB_BIT 0
`define FBSEL_RS485_BIT 1
`define FBSEL_RS232_BIT 2
`define FBSEL_CAN_BIT 3
`define FBSEL_ETHERNET_PORT_BIT 4
`define FBSEL_INDUSTRIAL_FIELDBUS_BIT 5
`define FBSEL_SPI_BIT 6
// protocols in the high half
`define FBSEL_SERIAL_MODBUS_BIT 16
`define FBSEL_TCP_MODBUS_BIT 17
`define FBSEL_INDUSTRIAL_PROTOCOL_BIT 18
`define FBSEL_PHYS_LSB 0
`define FBSEL_PHYS_MSB 15
`define FBSEL_PROTO_LSB 16
`define FBSEL_PROTO_MSB 31
// bits that carry a meaning in the common layout
`define FBSEL_DEFINED_MASK 32'h0007007f

// reset values
`define FBSEL_AVAIL_RST 32'h00000008
`define FBSEL_CTRL_RST 32'h00000008
`define FBSEL_COUNT_RST 8'h02
`define FBSEL_SWMASK_RST 32'h00000000
`define FBSEL_ACTIVE_RST 32'h00000008
`define FBSEL_CHANGES_RST 16'h0000

`endif

// ### shared/fbsel_pkg.sv
// fieldbus selection register bank: shared types
// assumes the register header is included by the design files
package fbsel_pkg;

  // bus slave handshake state, one-hot
  typedef enum logic [1:0] {
    FBSEL_BUS_IDLE = 2'b01,
    FBSEL_BUS_ACK = 2'b10
  } fbsel_bus_state_t;

  // one-hot register select produced by the address decoder
  typedef enum logic [6:0] {
    FBSEL_SEL_NONE = 7'h00,
    FBSEL_SEL_AVAIL = 7'h01,
    FBSEL_SEL_CTRL = 7'h02,
    FBSEL_SEL_COUNT = 7'h04,
    FBSEL_SEL_SWMASK = 7'h08,
    FBSEL_SEL_ACTIVE = 7'h10,
    FBSEL_SEL_CHANGES = 7'h20,
    FBSEL_SEL_UNMAPPED = 7'h40
  } fbsel_reg_sel_t;

  typedef logic [31:0] fbsel_word_t;

endpackage

// ### logic/fbsel_wb_slave.sv
// fieldbus selection register bank: classic wishbone slave front end
// assumes a classic single-cycle master that holds the request until ack
`timescale 1ns/1ps
`default_nettype none
`include "fbsel_regs.svh"

module fbsel_wb_slave #(
  parameter int ADDR_W = 16
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone request
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  // wishbone answer
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // towards the register bank
  input wire logic [31:0] rd_data_i,
  output fbsel_pkg::fbsel_reg_sel_t reg_sel_o,
  output logic wr_stb_o,
  output logic [31:0] wr_lanes_o
);

  fbsel_pkg::fbsel_bus_state_t state_q;
  fbsel_pkg::fbsel_bus_state_t state_d;
  logic ack_q;
  logic [31:0] dat_q;
  wire logic take_req;

  function automatic fbsel_pkg::fbsel_reg_sel_t fbsel_decode(input logic [ADDR_W-1:0] adr);
    fbsel_pkg::fbsel_reg_sel_t s;
    s = fbsel_pkg::FBSEL_SEL_UNMAPPED;
    if (adr == ADDR_W'(`FBSEL_ADDR_AVAIL))
      s = fbsel_pkg::FBSEL_SEL_AVAIL;
    else if (adr == ADDR_W'(`FBSEL_ADDR_CTRL))
      s = fbsel_pkg::FBSEL_SEL_CTRL;
    else if (adr == ADDR_W'(`FBSEL_ADDR_COUNT))
      s = fbsel_pkg::FBSEL_SEL_COUNT;
    else if (adr == ADDR_W'(`FBSEL_ADDR_SWMASK))
      s = fbsel_pkg::FBSEL_SEL_SWMASK;
    else if (adr == ADDR_W'(`FBSEL_ADDR_ACTIVE))
      s = fbsel_pkg::FBSEL_SEL_ACTIVE;
    else if (adr == ADDR_W'(`FBSEL_ADDR_CHANGES))
      s = fbsel_pkg::FBSEL_SEL_CHANGES;
    return s;
  endfunction

  // a request is taken once, in idle; the ack cycle blocks a second take
  assign take_req = wb_cyc_i & wb_stb_i & (state_q == fbsel_pkg::FBSEL_BUS_IDLE);
  assign reg_sel_o = take_req ? fbsel_decode(wb_adr_i) : fbsel_pkg::FBSEL_SEL_NONE;
  assign wr_stb_o = take_req & wb_we_i & ce_i;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign wr_lanes_o[8*g+7:8*g] = {8{wb_sel_i[g]}};
    end
  endgenerate

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      fbsel_pkg::FBSEL_BUS_IDLE:
      begin
        if (take_req)
          state_d = fbsel_pkg::FBSEL_BUS_ACK;
      end
      fbsel_pkg::FBSEL_BUS_ACK:
        state_d = fbsel_pkg::FBSEL_BUS_IDLE;
      default:
        state_d = fbsel_pkg::FBSEL_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= fbsel_pkg::FBSEL_BUS_IDLE;
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      ack_q <= take_req;
      if (take_req)
        dat_q <= wb_we_i ? 32'h00000000 : rd_data_i;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

endmodule
`default_nettype wire

// ### tb/fbsel_regs_chk.sv
// assertion checker for the fieldbus selection register bank
// assumes it is bound to fbsel_regs_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module fbsel_regs_chk #(
  parameter int ADDR_W = 16,
  parameter logic [31:0] AVAIL_FITTED = 32'h00000008,
  parameter logic [31:0] SWITCHABLE = 32'h00000000,
  parameter int CHANGE_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // settings and status
  input wire logic restore_stb_i,
  input wire logic [31:0] restore_data_i,
  input wire logic [31:0] save_data_o,
  input wire logic save_req_o,
  input wire logic [31:0] active_map_o,
  input wire logic active_change_o
);
  localparam logic [31:0] FIXED = ~SWITCHABLE;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged one cycle later");
  chk_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
  chk_fixed_active: assert property ((active_map_o & FIXED) == (32'h00000008 & FIXED))
    else $error("fixed active bit moved");
  chk_active_fitted: assert property ((active_map_o & ~AVAIL_FITTED) == (32'h00000008 & FIXED & ~AVAIL_FITTED))
    else $error("active bit set for an interface not fitted");
  // the map and its change pulse are loaded on the same edge
  chk_change_flag: assert property ($changed(active_map_o) |-> active_change_o)
    else $error("active map change not flagged");
  // the save pulse rises together with the ack of the write that moved bits
  chk_save_cause: assert property ($rose(save_req_o) |-> wb_ack_o && $past(wb_we_i))
    else $error("save request without a host write");
  chk_ctrl_fixed: assert property ((save_data_o & FIXED) == (32'h00000008 & FIXED))
    else $error("non-switchable control bit moved");
  chk_ctrl_cause: assert property ($changed(save_data_o) |-> wb_ack_o || $past(restore_stb_i))
    else $error("control word changed without write or restore");
  cov_write: cover property (wb_ack_o && wb_we_i);
  cov_change: cover property (active_change_o);
  cov_restore: cover property (restore_stb_i ##2 active_change_o);
endmodule
bind fbsel_regs_top fbsel_regs_chk #(.ADDR_W(ADDR_W), .AVAIL_FITTED(AVAIL_FITTED), .SWITCHABLE(SWITCHABLE),
  .CHANGE_W(CHANGE_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .restore_stb_i(restore_stb_i), .restore_data_i(restore_data_i),
  .save_data_o(save_data_o), .save_req_o(save_req_o), .active_map_o(active_map_o),
  .active_change_o(active_change_o));
`default_nettype wire

// ### tb/fbsel_host_model.sv
// host model: classic wishbone master reaching the register bank
// assumes one clock; the bench calls xfer and gets the read word back
`timescale 1ns/1ps
`default_nettype none
module fbsel_host_model (
  // clock
  input wire logic clk_i,
  // bus
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [15:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i
);
  initial
  begin
    {wb_cyc_o, wb_stb_o, wb_we_o} = 3'h0;
    {wb_adr_o, wb_sel_o, wb_dat_o} = 52'h0;
  end
  // gap idles the host first; released address and data lines get inverted so stale values never look valid
  task automatic xfer(input logic we, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
    input int gap, output logic [31:0] q, output bit ok);
    int n;
    n = 0;
    ok = 0;
    repeat (gap + 1) @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'h3, we};
    {wb_adr_o, wb_sel_o, wb_dat_o} <= {a, s, d};
    while (!ok && n < 40)
    begin
      @(posedge clk_i);
      n++;
      ok = (wb_ack_i === 1'b1);
    end
    q = wb_dat_i;
    {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'h0;
    {wb_adr_o, wb_dat_o} <= {~a, ~d};
  endtask
endmodule
`default_nettype wire

// ### tb/fbsel_regs_tb_top.sv
// self-checking bench for the fieldbus selection register bank
// assumes the host model drives the bus and the checker is bound to the top
`timescale 1ns/1ps
`default_nettype none
`include "fbsel_regs.svh"
module fbsel_regs_tb_top;
  localparam logic [31:0] FIT = 32'h00010019;
  localparam logic [31:0] SW = 32'h00010011;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rs_stb = 1'b0;
  logic ce = 1'b1;
  logic [31:0] rs_dat = 32'h0;
  logic cyc, stb, we, ack, save_req, act_chg;
  logic [15:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, save_data, act_map;
  int failures = 0;
  int total_checks = 0;
  int pulses = 0;
  int flips = 0;
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  fbsel_host_model host (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
    .wb_sel_o(sel), .wb_dat_o(wdat), .wb_ack_i(ack), .wb_dat_i(rdat));
  fbsel_regs_top #(.AVAIL_FITTED(FIT), .SWITCHABLE(SW)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_ack_o(ack), .wb_dat_o(rdat), .restore_stb_i(rs_stb), .restore_data_i(rs_dat),
    .save_data_o(save_data), .save_req_o(save_req), .active_map_o(act_map), .active_change_o(act_chg));
  always @(posedge clk_i) if (save_req === 1'b1) pulses++;
  always @(posedge clk_i) if (act_chg === 1'b1) flips++;
  task automatic finish_test();
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] q);
    bit ok;
    host.xfer(w, a, d, s, 0, q, ok);
    check("bus_ack", {31'h0, ok}, 32'h1);
    if (!ok) finish_test();
  endtask
  task automatic rd(input string name, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(name, q, exp);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask
  task automatic t_reset_values();
    check("active_port", act_map, 32'h00000008);
    check("save_port", save_data, 32'h00000008);
    rd("avail", `FBSEL_ADDR_AVAIL, FIT);
    rd("ctrl", `FBSEL_ADDR_CTRL, 32'h00000008);
    rd("count", `FBSEL_ADDR_COUNT, 32'h00000002);
    rd("mask", `FBSEL_ADDR_SWMASK, SW);
    rd("active", `FBSEL_ADDR_ACTIVE, 32'h00000008);
  endtask
  task automatic t_bit_walk();
    int bits[10] = '{0, 1, 2, 3, 4, 5, 6, 16, 17, 18};
    logic [31:0] exp, prev;
    int p0, f0, n;
    p0 = pulses;
    f0 = flips;
    prev = 32'h00000008;
    n = 0;
    foreach (bits[i])
    begin
      exp = 32'h00000008 | ((32'h1 << bits[i]) & SW);
      n += (exp != prev);
      prev = exp;
      wr(`FBSEL_ADDR_CTRL, 32'h1 << bits[i], 4'hf);
      #1;
      check("active_walk", act_map, exp & (FIT | 32'h8));
      rd("ctrl_walk", `FBSEL_ADDR_CTRL, exp);
    end
    repeat (3) @(posedge clk_i);
    check("save_pulses", pulses - p0, n);
    check("change_pulses", flips - f0, n);
  endtask
  task automatic t_lanes();
    wr(`FBSEL_ADDR_CTRL, 32'hffffffff, 4'h4);
    wr(`FBSEL_ADDR_CTRL, 32'h00000000, 4'hb);
    rd("ctrl_lanes", `FBSEL_ADDR_CTRL, 32'h00010008);
    rd("active_lanes", `FBSEL_ADDR_ACTIVE, 32'h00010008);
    // six map moves in the walk and one in the lane writes
    rd("change_count", `FBSEL_ADDR_CHANGES, 32'h00000007);
  endtask
  task automatic t_readonly();
    logic [15:0] a[5] = '{`FBSEL_ADDR_AVAIL, `FBSEL_ADDR_COUNT, `FBSEL_ADDR_SWMASK, `FBSEL_ADDR_ACTIVE, 16'h9000};
    logic [31:0] e[5] = '{FIT, 32'h2, SW, 32'h00010008, 32'h0};
    foreach (a[i])
    begin
      wr(a[i], 32'hffffffff, 4'hf);
      rd("read_only", a[i], e[i]);
    end
  endtask
  task automatic t_restore_and_reset();
    // a restore while the enable is low must leave the control word alone
    @(posedge clk_i);
    ce <= 1'b0;
    rs_dat <= 32'hffffffff;
    rs_stb <= 1'b1;
    @(posedge clk_i);
    ce <= 1'b1;
    rs_stb <= 1'b0;
    @(posedge clk_i);
    check("frozen_ctrl", save_data, 32'h00010008);
    @(posedge clk_i);
    rs_dat <= 32'hffffffff;
    rs_stb <= 1'b1;
    @(posedge clk_i);
    rs_stb <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("restored_ctrl", save_data, 32'h00010019);
    check("restored_active", act_map, 32'h00010019);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl_rerst", `FBSEL_ADDR_CTRL, 32'h00000008);
    check("active_rerst", act_map, 32'h00000008);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_bit_walk();
    t_lanes();
    t_readonly();
    t_restore_and_reset();
    finish_test();
  end
endmodule
`default_nettype wire
